/* File: design/tdi_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "tdi_regs.vh"
// Function
// (RQ1) Internal timing: retime on own transmit clock
// (RQ2) DTE centres data on transmit clock fall
// (RQ3) Near-fall transition moves retiming to rising edge
// (RQ4) External timing uses DTE terminal timing clock
// (RQ5) External timing defaults to terminal clock fall
// (RQ6) Near terminal-clock fall: use rising edge
// (RQ7) Drive receive clock, data synchronous to it
// (RQ8) Internal receive clock falls mid data bit
// (RQ9) Receive retiming rising normal, falling inverted
// (RQ10) Read/write control register configures interface
// (RQ11) Read-only status register shows interface state
// (RQ12) Flow register drives CTS/DSR/CD, reads RTS/DTR
// (RQ13) RTS state readable in flow register
// (RQ14) DTR state readable in flow register
// (RQ15) CTS off after reset until set
// (RQ16) DSR, carrier detect off until set
// (RQ17) Chosen edge holds until next near-edge transition; code holds the rising edge until a clear bit write or mode change
// (RQ18) Control bit loops transmit data to receive
module tdi_top (
    // Clock and reset
    input  wire        clock,
    input  wire        reset_n,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Transmit side pins
    input  wire        transmit_data_in,
    input  wire        dte_terminal_timing_clock,
    output wire        dce_transmit_clock,
    // Internal transmit side
    input  wire        tx_clock_gen,
    output reg         tx_data_out,
    output reg         tx_bit_strobe,
    // Receive side
    input  wire        internal_receive_clock,
    input  wire        rx_data_in,
    output wire        recovered_receive_clock_out,
    output reg         rx_data_out,
    // Control lines
    input  wire        rts_in,
    input  wire        dtr_in,
    output wire        cts_out,
    output wire        dsr_out,
    output wire        carrier_detect_out
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg  [6:0] sync1_ff;
    reg  [6:0] sync2_ff;
    reg  [1:0] last_ff;
    always @(posedge clock) begin
        if (!reset_n) begin
            sync1_ff <= 7'h00;
            sync2_ff <= 7'h00;
        end else begin
            sync1_ff <= {dtr_in, rts_in, rx_data_in, internal_receive_clock,
                         transmit_data_in, dte_terminal_timing_clock, tx_clock_gen};
            sync2_ff <= sync1_ff;
        end
    end
    wire st_s   = sync2_ff[0];
    wire tt_s   = sync2_ff[1];
    wire sd_s   = sync2_ff[2];
    wire rxc_s  = sync2_ff[3];
    wire rxd_s  = sync2_ff[4];
    wire rts_s  = sync2_ff[5];
    wire dtr_s  = sync2_ff[6];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [3:0] ctrl_ff;
    reg  [2:0] flow_ff;
    reg        sd_last_ff;
    wire       wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Writes land on the edge that completes the cycle, with ack high
    wire       wr_en    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    wire       ext_mode = ctrl_ff[`TDI_CTRL_EXT_BIT];
    wire       rx_inv   = ctrl_ff[`TDI_CTRL_RXINV_BIT];
    wire       loop_en  = ctrl_ff[`TDI_CTRL_LOOP_BIT];
    wire       clr_ph   = wr_en && (wb_adr_i == `TDI_CTRL_ADDR)
                          && wb_dat_i[`TDI_CTRL_CLRPH_BIT];
    wire       use_rise;

    // Transmit clock source: own clock or DTE terminal timing
    wire tclk_s = ext_mode ? tt_s : st_s;                 // [RQ1] [RQ4]
    assign dce_transmit_clock = tx_clock_gen;             // [RQ1]

    // Edge events in the sampled domain
    wire tclk_fall = last_ff[0] & ~tclk_s;
    wire tclk_rise = ~last_ff[0] & tclk_s;
    wire rxc_fall  = last_ff[1] & ~rxc_s;
    wire rxc_rise  = ~last_ff[1] & rxc_s;
    wire sd_edge   = sd_last_ff ^ sd_s;
    always @(posedge clock) begin
        if (!reset_n) begin
            last_ff    <= 2'h0;
            sd_last_ff <= 1'b0;
        end else begin
            last_ff    <= {rxc_s, tclk_s};
            sd_last_ff <= sd_s;
        end
    end

    // ----------------------------------------
    // Phase correction monitor
    // ----------------------------------------
    // Mode change restarts at the default falling edge
    wire mode_chg = wr_en && (wb_adr_i == `TDI_CTRL_ADDR)
                    && (wb_dat_i[`TDI_CTRL_EXT_BIT] != ext_mode);
    tdi_edge_mon #(
        .GUARD       (`TDI_GUARD_CYC)
    ) u_mon (
        .clock       (clock),
        .reset_n     (reset_n),
        .fall_evt    (tclk_fall),
        .data_evt    (sd_edge),
        .clear       (clr_ph | mode_chg),
        .use_rise_ff (use_rise)
    );

    // ----------------------------------------
    // Transmit retiming
    // ----------------------------------------
    // Default falling edge; rising only when monitor demands it
    wire tx_take = use_rise ? tclk_rise : tclk_fall;      // [RQ3] [RQ5] [RQ6]
    always @(posedge clock) begin
        if (!reset_n) begin
            tx_data_out   <= 1'b0;
            tx_bit_strobe <= 1'b0;
        end else begin
            tx_bit_strobe <= tx_take;
            if (tx_take)
                tx_data_out <= sd_s;                      // [RQ2] [RQ4]
        end
    end

    // ----------------------------------------
    // Receive path
    // ----------------------------------------
    // Data sampled mid bit at falling edge of internal receive clock
    reg  rx_mid_ff;
    always @(posedge clock) begin
        if (!reset_n)
            rx_mid_ff <= 1'b0;
        else if (rxc_fall)
            rx_mid_ff <= loop_en ? tx_data_out : rxd_s;   // [RQ8] [RQ18]
    end
    // Normal retimes on rising edge, inverted on falling edge
    always @(posedge clock) begin
        if (!reset_n)
            rx_data_out <= 1'b0;
        else if (rx_inv ? rxc_fall : rxc_rise)
            rx_data_out <= loop_en ? tx_data_out : rx_mid_ff; // [RQ9] [RQ18]
    end
    // Clock delayed by the synchroniser so data and clock stay aligned
    reg rt_ff;
    always @(posedge clock) begin
        if (!reset_n)
            rt_ff <= 1'b0;
        else
            rt_ff <= rxc_s;                               // [RQ7]
    end
    assign recovered_receive_clock_out = rt_ff;           // [RQ7]

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge clock) begin
        if (!reset_n) begin
            ctrl_ff <= `TDI_CTRL_RST;
            flow_ff <= `TDI_FLOW_RST;                     // [RQ15] [RQ16]
        end else if (wr_en) begin
            if (wb_adr_i == `TDI_CTRL_ADDR)
                ctrl_ff <= {1'b0, wb_dat_i[2:0]};         // [RQ10]
            if (wb_adr_i == `TDI_FLOW_ADDR)
                flow_ff <= wb_dat_i[2:0];                 // [RQ12]
        end
    end
    assign cts_out            = flow_ff[`TDI_FLOW_CTS_BIT];  // [RQ12] [RQ15]
    assign dsr_out            = flow_ff[`TDI_FLOW_DSR_BIT];  // [RQ16]
    assign carrier_detect_out = flow_ff[`TDI_FLOW_CD_BIT];   // [RQ16]

    // ----------------------------------------
    // Register reads and acknowledge
    // ----------------------------------------
    // One wait-free ack cycle; unmapped addresses ack with zero data
    reg [31:0] nxt_rdata;
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (wb_adr_i)
            `TDI_CTRL_ADDR:   nxt_rdata = {29'h0000_0000, ctrl_ff[2:0]};
            `TDI_STATUS_ADDR: nxt_rdata = {28'h000_0000, loop_en, rx_inv,
                                           ext_mode, use_rise};       // [RQ11]
            `TDI_FLOW_ADDR:   nxt_rdata = {26'h000_0000, dtr_s, rts_s,
                                           1'b0, flow_ff};            // [RQ13] [RQ14]
            default:          nxt_rdata = 32'h0000_0000;
        endcase
    end
    always @(posedge clock) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i)
                wb_dat_o <= nxt_rdata;
        end
    end
endmodule // tdi_top
`default_nettype wire

/* File: design/tdi_regs.vh */
`ifndef TDI_REGS_VH
`define TDI_REGS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TDI_CTRL_ADDR      8'h00
`define TDI_STATUS_ADDR    8'h04
`define TDI_FLOW_ADDR      8'h08
// ----------------------------------------
// Control fields
// ----------------------------------------
`define TDI_CTRL_EXT_BIT   0
`define TDI_CTRL_RXINV_BIT 1
`define TDI_CTRL_LOOP_BIT  2
`define TDI_CTRL_CLRPH_BIT 3
`define TDI_CTRL_RST       4'h0
// ----------------------------------------
// Status fields
// ----------------------------------------
`define TDI_STAT_TXRISE_BIT 0
`define TDI_STAT_EXT_BIT    1
`define TDI_STAT_RXINV_BIT  2
`define TDI_STAT_LOOP_BIT   3
// ----------------------------------------
// Data flow fields
// ----------------------------------------
`define TDI_FLOW_CTS_BIT   0
`define TDI_FLOW_DSR_BIT   1
`define TDI_FLOW_CD_BIT    2
`define TDI_FLOW_RTS_BIT   4
`define TDI_FLOW_DTR_BIT   5
`define TDI_FLOW_RST       3'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define TDI_CLK_NS         25
`define TDI_GUARD_NS       12
`define TDI_GUARD_CYC      (((`TDI_GUARD_NS) + (`TDI_CLK_NS) - 1) / (`TDI_CLK_NS))
`endif

/* File: design/tdi_edge_mon.v */
`timescale 1ns/1ps
`default_nettype none
// Phase monitor: watches data transitions near the clock falling edge
// and latches the retiming edge choice until it is cleared.
module tdi_edge_mon #(
    parameter GUARD = 1
) (
    // Clock and reset
    input  wire clock,
    input  wire reset_n,
    // Events, same clock domain
    input  wire fall_evt,
    input  wire data_evt,
    input  wire clear,
    // Choice
    output reg  use_rise_ff
);
    reg  [3:0] since_fall_ff;
    reg  [3:0] since_data_ff;
    reg        nxt_use_rise;
    // ----------------------------------------
    // Distance from the last falling edge
    // ----------------------------------------
    always @(posedge clock) begin
        if (!reset_n)
            since_fall_ff <= 4'hf;
        else if (fall_evt)
            since_fall_ff <= 4'h0;
        else if (since_fall_ff != 4'hf)
            since_fall_ff <= since_fall_ff + 4'h1;
    end
    // Distance from the last data transition, for edges just before a fall
    always @(posedge clock) begin
        if (!reset_n)
            since_data_ff <= 4'hf;
        else if (data_evt)
            since_data_ff <= 4'h0;
        else if (since_data_ff != 4'hf)
            since_data_ff <= since_data_ff + 4'h1;
    end
    // Near-edge transition moves to rising edge; it sticks so the choice
    // does not chatter bit by bit
    always @* begin
        nxt_use_rise = use_rise_ff;
        if (clear)
            nxt_use_rise = 1'b0;
        // Guard window applies on both sides of the falling edge
        if (data_evt && (fall_evt || since_fall_ff < GUARD[3:0]))
            nxt_use_rise = 1'b1;                      // [RQ3] [RQ6] [RQ17]
        if (fall_evt && since_data_ff < GUARD[3:0])
            nxt_use_rise = 1'b1;                      // [RQ3] [RQ6]
    end
    always @(posedge clock) begin
        if (!reset_n)
            use_rise_ff <= 1'b0;
        else
            use_rise_ff <= nxt_use_rise;
    end
endmodule // tdi_edge_mon
`default_nettype wire

/* File: verification/tdi_dte_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tdi_dte_model (
    // Clock
    input  wire logic clock,
    // Scenario knobs
    input  wire logic ext,
    input  wire logic near,
    input  wire logic hold,
    input  wire logic req,
    // Line side
    input  wire logic dce_transmit_clock,
    output var  logic dte_terminal_timing_clock,
    output var  logic transmit_data_in,
    output var  logic rts_in,
    output var  logic dtr_in
);
    logic [2:0] cnt = 3'h5;
    logic       prv = 1'b0;
    wire  logic sc = ext ? dte_terminal_timing_clock : dce_transmit_clock;
    initial {dte_terminal_timing_clock, transmit_data_in, rts_in, dtr_in} = 4'h0;
    // Data moves on the clock rise, so the fall sits mid bit; near skews it
    always @(posedge clock) begin
        cnt <= cnt + 3'h1;
        dte_terminal_timing_clock <= cnt[2];
        prv <= sc;
        if (hold)
            transmit_data_in <= 1'b1;
        else if (near ? (prv & !sc) : (!prv & sc))
            transmit_data_in <= !transmit_data_in;
        rts_in <= req;
        dtr_in <= 1'b1;
    end
endmodule // tdi_dte_model
`default_nettype wire

/* File: verification/tdi_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tdi_regs.vh"
module tdi_chk (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    // Line side
    input wire logic        tx_clock_gen,
    input wire logic        dce_transmit_clock,
    input wire logic        tx_data_out,
    input wire logic        tx_bit_strobe,
    input wire logic        internal_receive_clock,
    input wire logic        recovered_receive_clock_out,
    input wire logic        cts_out,
    input wire logic        dsr_out,
    input wire logic        carrier_detect_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Cycles since reset, so the clock pipeline check skips flushed stages
    logic [1:0] up_cnt_ff;
    always @(posedge clock) begin
        if (!reset_n)
            up_cnt_ff <= 2'h0;
        else if (up_cnt_ff != 2'h3)
            up_cnt_ff <= up_cnt_ff + 2'h1;
    end
    rt_follow_a: assert property (up_cnt_ff == 2'h3
        |-> recovered_receive_clock_out == $past(internal_receive_clock, 3))
        else $error("receive clock out not following pin");
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without strobe");
    cts_rst_a: assert property (disable iff (1'b0) !reset_n |=> !cts_out)
        else $error("cts on in reset");
    flow_rst_a: assert property (disable iff (1'b0) !reset_n |=> !dsr_out && !carrier_detect_out)
        else $error("dsr or cd on in reset");
    flow_wr_a: assert property (wb_ack_o && wb_cyc_i && wb_we_i && wb_sel_i[0]
        && wb_adr_i == `TDI_FLOW_ADDR |=> {carrier_detect_out, dsr_out, cts_out}
        == $past(wb_dat_i[2:0]))
        else $error("flow outputs differ from write");
    st_pass_a: assert property (dce_transmit_clock == tx_clock_gen)
        else $error("transmit clock not passed");
    tx_load_a: assert property ($changed(tx_data_out) |-> tx_bit_strobe)
        else $error("data moved without strobe");
endmodule // tdi_chk
bind tdi_top tdi_chk i_tdi_chk (.*);
`default_nettype wire

/* File: verification/tdi_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tdi_regs.vh"
module tdi_top_test;
    logic clock = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic wb_ack_o, dce_transmit_clock, tx_data_out, tx_bit_strobe, rx_data_out;
    logic recovered_receive_clock_out, cts_out, dsr_out, carrier_detect_out;
    logic transmit_data_in, dte_terminal_timing_clock, rts_in, dtr_in;
    logic tx_clock_gen = 1'b0, internal_receive_clock = 1'b0, rx_data_in = 1'b0;
    logic ext = 1'b0, near = 1'b0, hold = 1'b0, req = 1'b0, rxv = 1'b0;
    logic [2:0] ph = 3'h0;
    int error_cnt = 0, num_checks = 0, nstb = 0, s;
    tdi_top i_tdi_top (.*);
    tdi_dte_model i_tdi_dte_model (.*);
    always #12.5 clock = !clock;
    // Modem clocks of eight cycles; the send clock stops in external timing
    always @(posedge clock) begin
        ph <= ph + 3'h1;
        if (!ext)
            tx_clock_gen <= ph[2];
        internal_receive_clock <= ph[1] ^ ph[2];
        if (ph == 3'h2)
            rx_data_in <= rxv;
        if (tx_bit_strobe === 1'b1)
            nstb <= nstb + 1;
    end
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task wb(input logic w, input logic [7:0] a, input logic [3:0] m, input logic [31:0] d);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, m, d};
        // Hold the request until ack; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, 4'h1, d);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 4'hF, 32'h0000_0000);
        cmp(rd, exp);
    endtask
    task bits(input int n);
        repeat (n * 8) @(posedge clock);
    endtask
    // Exactly four strobes in four bit times
    task strobes;
        // Skip one bit so a clear still in flight cannot add a strobe
        bits(1);
        s = nstb;
        bits(4);
        cmp(32'(nstb - s), 32'h0000_0004);
    endtask
    task wrap_up;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        // Let the DTE lines through the synchronisers before reading them
        repeat (3) @(posedge clock);
        rc(`TDI_FLOW_ADDR, 32'h0000_0020);
        cmp({29'h0, carrier_detect_out, dsr_out, cts_out}, 32'h0);
        wr(`TDI_CTRL_ADDR, 32'h0000_000E);
        rc(`TDI_CTRL_ADDR, 32'h0000_0006);
        wr(`TDI_STATUS_ADDR, 32'h0000_000F);
        rc(`TDI_STATUS_ADDR, 32'h0000_000C);
        rc(8'h0C, 32'h0000_0000);
        wb(1'b1, `TDI_FLOW_ADDR, 4'h2, 32'h0000_0007);
        rc(`TDI_FLOW_ADDR, 32'h0000_0020);
        req <= 1'b1;
        wr(`TDI_FLOW_ADDR, 32'h0000_0005);
        rc(`TDI_FLOW_ADDR, 32'h0000_0035);
        cmp({29'h0, carrier_detect_out, dsr_out, cts_out}, 32'h5);
        // Loopback carries the send line back to the receive side
        hold <= 1'b1;
        wr(`TDI_CTRL_ADDR, 32'h0000_0004);
        bits(6);
        cmp({31'h0, tx_data_out}, 32'h1);
        cmp({31'h0, rx_data_out}, 32'h1);
        wr(`TDI_CTRL_ADDR, 32'h0000_0000);
        bits(6);
        cmp({31'h0, rx_data_out}, 32'h0);
        rxv <= 1'b1;
        wr(`TDI_CTRL_ADDR, 32'h0000_0002);
        bits(6);
        cmp({31'h0, rx_data_out}, 32'h1);
        // Edge choice follows near-fall transitions and then holds
        hold <= 1'b0;
        wr(`TDI_CTRL_ADDR, 32'h0000_0008);
        strobes();
        rc(`TDI_STATUS_ADDR, 32'h0000_0000);
        near <= 1'b1;
        bits(4);
        rc(`TDI_STATUS_ADDR, 32'h0000_0001);
        near <= 1'b0;
        bits(4);
        rc(`TDI_STATUS_ADDR, 32'h0000_0001);
        wr(`TDI_CTRL_ADDR, 32'h0000_0008);
        bits(4);
        rc(`TDI_STATUS_ADDR, 32'h0000_0000);
        // Settle the switch-over glitch before clearing the choice
        ext <= 1'b1;
        wr(`TDI_CTRL_ADDR, 32'h0000_0001);
        bits(2);
        wr(`TDI_CTRL_ADDR, 32'h0000_0009);
        strobes();
        rc(`TDI_STATUS_ADDR, 32'h0000_0002);
        near <= 1'b1;
        bits(4);
        rc(`TDI_STATUS_ADDR, 32'h0000_0003);
        strobes();
        wrap_up();
    end
    // Cut a hung run short
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
endmodule // tdi_top_test
`default_nettype wire
